// ---- rtl/setw_pkg.sv ----
/*
 constants, field positions and state types shared by both link ends.
 assumes a single 50 MHz ref_clk on both ends.
*/
// What this block does
// RULE_01: data changes only while clock low
// RULE_02: start opens every command
// RULE_03: stop closes every operation
// RULE_04: receiver acknowledges every byte
// RULE_05: master gives ninth clock for acknowledge
// RULE_06: acknowledge held low through clock high
// RULE_07: master withholds acknowledge after last read
// RULE_08: device releases data after missing acknowledge
// RULE_09: write protect blocks all programming
// RULE_10: unprotected allows read and write everywhere
// RULE_11: master alone starts transfers, drives clock
// RULE_12: only chip select bit compared; rest block
// RULE_13: device data output is open drain
// RULE_14: all bits shifted by serial clock
// RULE_15: program cycle ends within 10 ms
// RULE_16: page write takes up to 16 bytes
// RULE_17: 8192 bit array, block bits plus word
// RULE_18: control byte: code, chip select, two block bits, direction
// RULE_19: page write wraps low four address bits
// RULE_20: stop starts program; no acknowledge while busy
// RULE_21: protected: refuse first data byte, no program
// RULE_22: mid-byte start or stop abandons transfer
package setw_pkg;
    localparam int unsigned SETW_CLK_HZ     = 50_000_000;
    localparam int unsigned SETW_TWR_MS     = 10;
    localparam int unsigned SETW_TWR_CYC    = SETW_CLK_HZ / 1000 * SETW_TWR_MS;
    localparam int unsigned SETW_QTR_CYC    = 2;
    localparam int unsigned SETW_FIFO_DEPTH = 8;
    localparam int unsigned SETW_PAGE_BYTES = 16;
    localparam int unsigned SETW_MEM_BYTES  = 1024;
    localparam logic [3:0]  SETW_ACK_SLOT   = 4'h8;
    localparam logic [3:0]  SETW_LAST_BIT   = 4'h7;
    localparam logic [3:0]  SETW_CODE_DFLT  = 4'h5; // arbitrary value
    localparam int unsigned SETW_CODE_LSB   = 4;
    localparam int unsigned SETW_CS_POS     = 3;
    localparam int unsigned SETW_BLK_LSB    = 1;
    localparam int unsigned SETW_RW_POS     = 0;

    typedef enum logic [2:0] {
        SETW_D_IDLE = 3'b000,
        SETW_D_CTRL = 3'b001,
        SETW_D_WADR = 3'b011,
        SETW_D_WDAT = 3'b010,
        SETW_D_RDAT = 3'b110
    } setw_dst_t;

    typedef enum logic [2:0] {
        SETW_H_IDLE  = 3'b000,
        SETW_H_START = 3'b001,
        SETW_H_BYTE  = 3'b011,
        SETW_H_STOP  = 3'b010,
        SETW_H_LOAD  = 3'b111
    } setw_hst_t;

    typedef enum logic [2:0] {
        SETW_R_CTLW = 3'b000,
        SETW_R_WADR = 3'b001,
        SETW_R_WDAT = 3'b011,
        SETW_R_CTLR = 3'b010,
        SETW_R_RDAT = 3'b110
    } setw_role_t;
endpackage : setw_pkg

// ---- rtl/setw_if.sv ----
/*
 two-wire link between master end and memory end.
 assumes a pull-up: the data wire is low only while some end pulls it.
*/
`timescale 1ns/10ps
`default_nettype none
interface setw_if;
    logic scl;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic sda;

    assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

    modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
    modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface : setw_if
`default_nettype wire

// ---- rtl/setw_fifo.sv ----
/*
 small synchronous fifo with valid/ready on both sides.
 assumes DEPTH is a power of two.
*/
`timescale 1ns/10ps
`default_nettype none
module setw_fifo import setw_pkg::*; #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = SETW_FIFO_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;

    assign out_valid = wp_r != rp_r;
    assign in_ready  = wp_r != {~rp_r[AW], rp_r[AW-1:0]};
    assign out_data  = mem[rp_r[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule : setw_fifo
`default_nettype wire

// ---- rtl/setw_dev.sv ----
/*
 memory end: serial slave, page buffer, array and self-timed programming.
 assumes the master keeps the link protocol; link pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module setw_dev import setw_pkg::*; #(
    parameter logic [3:0]  DEV_CODE    = SETW_CODE_DFLT, // arbitrary value
    parameter int unsigned PROG_CYCLES = SETW_TWR_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic wp,
    input  wire logic chip_select_address_pin,
    output logic      busy,
    setw_if.dev       link
);
    localparam int unsigned BW = $clog2(PROG_CYCLES + 1);

    setw_dst_t   st_r;
    logic [1:0]  scl_s_r;
    logic [1:0]  sda_s_r;
    logic [1:0]  wp_s_r;
    logic [1:0]  cs_s_r;
    logic        scl_p_r;
    logic        sda_p_r;
    logic [3:0]  cnt_r;
    logic [7:0]  sh_r;
    logic [7:0]  tx_r;
    logic        ack_r;
    logic        rw_r;
    logic        oe_r;
    logic [9:0]  addr_r;
    logic [5:0]  base_r;
    logic [7:0]  pbuf [SETW_PAGE_BYTES];
    logic [15:0] pval_r;
    logic        busy_r;
    logic [BW-1:0] bcnt_r;
    logic [7:0]  mem [SETW_MEM_BYTES];

    logic       scl_now;
    logic       sda_now;
    logic       wp_now;
    logic       start_ev;
    logic       stop_ev;
    logic       rise;
    logic       fall;
    logic [7:0] byte_in;
    logic       match;
    logic       byte_done;
    logic       slot_done;
    logic       go;

    // first stages feed only the second stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            wp_s_r  <= 2'h0;
            cs_s_r  <= 2'h0;
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], link.scl};
            sda_s_r <= {sda_s_r[0], link.sda};
            wp_s_r  <= {wp_s_r[0], wp};
            cs_s_r  <= {cs_s_r[0], chip_select_address_pin};
            scl_p_r <= scl_s_r[1];
            sda_p_r <= sda_s_r[1];
        end
    end

    assign scl_now  = scl_s_r[1];
    assign sda_now  = sda_s_r[1];
    assign wp_now   = wp_s_r[1];
    assign start_ev = scl_now && scl_p_r && sda_p_r && !sda_now; // RULE_02 RULE_01
    assign stop_ev  = scl_now && scl_p_r && !sda_p_r && sda_now; // RULE_03 RULE_01
    assign rise     = scl_now && !scl_p_r; // RULE_14
    assign fall     = !scl_now && scl_p_r;
    assign byte_in  = {sh_r[6:0], sda_now};
    assign match    = byte_in[7:SETW_CODE_LSB] == DEV_CODE
                   && byte_in[SETW_CS_POS] == cs_s_r[1]; // RULE_12 RULE_18
    assign byte_done = rise && st_r != SETW_D_IDLE && cnt_r == SETW_LAST_BIT;
    assign slot_done = rise && st_r != SETW_D_IDLE && cnt_r == SETW_ACK_SLOT;
    // a stop one clock after a data-byte ack programs; any other does not
    assign go = stop_ev && st_r == SETW_D_WDAT && cnt_r == 4'h1
             && |pval_r && !wp_now && !busy_r; // RULE_20 RULE_22 RULE_09 RULE_21
    assign busy = busy_r;
    assign link.d_sda_o  = 1'b0; // RULE_13
    assign link.d_sda_oe = oe_r; // RULE_13

    // bit position and byte sequence
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r  <= SETW_D_IDLE;
            cnt_r <= 4'h0;
        end else if (start_ev) begin
            st_r  <= SETW_D_CTRL; // RULE_22
            cnt_r <= 4'h0;
        end else if (stop_ev) begin
            st_r  <= SETW_D_IDLE; // RULE_22
            cnt_r <= 4'h0;
        end else if (rise && st_r != SETW_D_IDLE) begin
            if (cnt_r != SETW_ACK_SLOT) begin
                cnt_r <= cnt_r + 4'h1;
            end else begin
                cnt_r <= 4'h0;
                if (st_r == SETW_D_RDAT) begin
                    st_r <= sda_now ? SETW_D_IDLE : SETW_D_RDAT; // RULE_08
                end else if (!ack_r) begin
                    st_r <= SETW_D_IDLE;
                end else begin
                    case (st_r)
                        SETW_D_CTRL: begin
                            st_r <= rw_r ? SETW_D_RDAT : SETW_D_WADR;
                        end
                        SETW_D_WADR: begin
                            st_r <= SETW_D_WDAT;
                        end
                        default: begin
                            st_r <= st_r;
                        end
                    endcase
                end
            end
        end
    end

    // incoming shift and the acknowledge decision
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sh_r  <= 8'h00;
            ack_r <= 1'b0;
            rw_r  <= 1'b0;
        end else if (start_ev) begin
            ack_r <= 1'b0;
        end else if (rise && st_r != SETW_D_IDLE && cnt_r != SETW_ACK_SLOT) begin
            sh_r <= byte_in;
            if (byte_done) begin
                case (st_r)
                    SETW_D_CTRL: begin
                        ack_r <= match && !busy_r; // RULE_20
                        rw_r  <= byte_in[SETW_RW_POS];
                    end
                    SETW_D_WADR: begin
                        ack_r <= 1'b1; // RULE_21
                    end
                    SETW_D_WDAT: begin
                        ack_r <= !wp_now; // RULE_21 RULE_10
                    end
                    default: begin
                        ack_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // address pointer: block bits from the control byte, word from the next
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_r <= 10'h000;
        end else if (byte_done) begin
            case (st_r)
                SETW_D_CTRL: begin
                    if (match && !busy_r) begin
                        addr_r[9:8] <= byte_in[SETW_BLK_LSB+1:SETW_BLK_LSB]; // RULE_17
                    end
                end
                SETW_D_WADR: begin
                    addr_r[7:0] <= byte_in;
                end
                SETW_D_WDAT: begin
                    if (!wp_now) begin
                        addr_r[3:0] <= addr_r[3:0] + 4'h1; // RULE_19
                    end
                end
                default: begin
                    addr_r <= addr_r + 10'h001;
                end
            endcase
        end
    end

    // page buffer; a later byte to the same slot overwrites the earlier
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pval_r <= 16'h0000;
            base_r <= 6'h00;
        end else if (busy_r && bcnt_r == BW'(PROG_CYCLES - 1)) begin
            pval_r <= 16'h0000;
        end else if (start_ev && !busy_r) begin
            pval_r <= 16'h0000; // RULE_22
        end else if (byte_done && st_r == SETW_D_WADR) begin
            base_r <= {addr_r[9:8], byte_in[7:4]};
        end else if (byte_done && st_r == SETW_D_WDAT && !wp_now) begin
            pval_r[addr_r[3:0]] <= 1'b1; // RULE_16 RULE_19
        end
    end

    always_ff @(posedge ref_clk) begin
        if (byte_done && st_r == SETW_D_WDAT && !wp_now) begin
            pbuf[addr_r[3:0]] <= byte_in; // RULE_16
        end
    end

    // self-timed program cycle; copy takes the first sixteen cycles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            bcnt_r <= '0;
        end else if (go) begin
            busy_r <= 1'b1; // RULE_20
            bcnt_r <= '0;
        end else if (busy_r) begin
            bcnt_r <= bcnt_r + 1'b1;
            if (bcnt_r == BW'(PROG_CYCLES - 1)) begin
                busy_r <= 1'b0; // RULE_15
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (busy_r && bcnt_r < BW'(SETW_PAGE_BYTES) && pval_r[bcnt_r[3:0]]) begin
            mem[{base_r, bcnt_r[3:0]}] <= pbuf[bcnt_r[3:0]]; // RULE_17
        end
    end

    // outgoing byte, loaded at the read control byte's ack slot and at each ack slot the master acknowledges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_r <= 8'hff;
        end else if (slot_done && st_r == SETW_D_CTRL && ack_r && rw_r) begin
            tx_r <= mem[addr_r];
        end else if (slot_done && st_r == SETW_D_RDAT && !sda_now) begin
            tx_r <= mem[addr_r]; // RULE_04
        end else if (rise && st_r == SETW_D_RDAT && cnt_r != SETW_ACK_SLOT) begin
            tx_r <= {tx_r[6:0], 1'b1};
        end
    end

    // pin changes just after a falling clock edge, or is released on a start or stop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            oe_r <= 1'b0;
        end else if (start_ev || stop_ev) begin
            oe_r <= 1'b0;
        end else if (fall) begin
            if (st_r == SETW_D_RDAT) begin
                oe_r <= cnt_r != SETW_ACK_SLOT && !tx_r[7]; // RULE_01 RULE_08
            end else if (st_r != SETW_D_IDLE && cnt_r == SETW_ACK_SLOT) begin
                oe_r <= ack_r; // RULE_04 RULE_06
            end else begin
                oe_r <= 1'b0;
            end
        end
    end
endmodule : setw_dev
`default_nettype wire

// ---- rtl/setw_host.sv ----
/*
 master end: runs byte commands over the link, clock from a divider.
 assumes write bytes arrive through the fifo; read bytes are not stalled.
*/
`timescale 1ns/10ps
`default_nettype none
module setw_host import setw_pkg::*; #(
    parameter logic [3:0]  DEV_CODE = SETW_CODE_DFLT, // arbitrary value
    parameter int unsigned QTR_CYC  = SETW_QTR_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_read,
    input  wire logic       cmd_dev_sel,
    input  wire logic [9:0] cmd_addr,
    input  wire logic [4:0] cmd_len,
    input  wire logic       wr_valid,
    output logic            wr_ready,
    input  wire logic [7:0] wr_data,
    output logic            rd_valid,
    output logic      [7:0] rd_data,
    output logic            done,
    output logic            nack,
    setw_if.host            link
);
    localparam int unsigned TW = $clog2(QTR_CYC + 1);

    setw_hst_t  hs_r;
    setw_role_t role_r;
    logic [TW-1:0] tc_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [4:0] len_r;
    logic [2:0] ctl_r;
    logic       rd_r;
    logic       scl_r;
    logic       oe_r;
    logic [1:0] sda_s_r;
    logic       fo_valid;
    logic       fo_ready;
    logic [7:0] fo_data;
    logic       tick;
    logic       eob;
    logic       ackd;

    setw_fifo #(.WIDTH(8), .DEPTH(SETW_FIFO_DEPTH)) u_wfifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (fo_valid),
        .out_ready (fo_ready),
        .out_data  (fo_data)
    );

    assign cmd_ready = hs_r == SETW_H_IDLE;
    assign fo_ready  = hs_r == SETW_H_LOAD;
    assign tick = tc_r == TW'(QTR_CYC - 1);
    assign eob  = tick && q_r == 2'h3;
    assign ackd = !sda_s_r[1];
    assign link.scl      = scl_r; // RULE_11
    assign link.h_sda_o  = 1'b0;
    assign link.h_sda_oe = oe_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sda_s_r <= 2'h3;
        end else begin
            sda_s_r <= {sda_s_r[0], link.sda};
        end
    end

    // quarter-bit divider; it stands in idle and while waiting on the fifo
    always_ff @(posedge ref_clk) begin
        if (rst || hs_r == SETW_H_IDLE || hs_r == SETW_H_LOAD) begin
            tc_r <= '0;
            q_r  <= 2'h0;
        end else if (tick) begin
            tc_r <= '0;
            q_r  <= q_r + 2'h1;
        end else begin
            tc_r <= tc_r + 1'b1;
        end
    end

    // line levels; data bits move in the low quarters, start and stop data in the last high quarter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_r <= 1'b1;
            oe_r  <= 1'b0;
        end else begin
            case (hs_r)
                SETW_H_START: begin
                    // low half first lets a device ack end
                    scl_r <= q_r[1];
                    oe_r  <= q_r == 2'h3; // RULE_02
                end
                SETW_H_BYTE: begin
                    scl_r <= q_r[1]; // RULE_05 RULE_01
                    if (bit_r != SETW_ACK_SLOT) begin
                        oe_r <= role_r != SETW_R_RDAT && !tx_r[7];
                    end else begin
                        oe_r <= role_r == SETW_R_RDAT && len_r != 5'h01; // RULE_04 RULE_07
                    end
                end
                SETW_H_STOP: begin
                    scl_r <= q_r[1];
                    oe_r  <= q_r != 2'h3; // RULE_03
                end
                SETW_H_LOAD: begin
                    scl_r <= 1'b0;
                    oe_r  <= 1'b0;
                end
                default: begin
                    scl_r <= 1'b1;
                    oe_r  <= 1'b0;
                end
            endcase
        end
    end

    // command sequencing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hs_r     <= SETW_H_IDLE;
            role_r   <= SETW_R_CTLW;
            bit_r    <= 4'h0;
            tx_r     <= 8'hff;
            rx_r     <= 8'h00;
            len_r    <= 5'h00;
            ctl_r    <= 3'h0;
            rd_r     <= 1'b0;
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
            done     <= 1'b0;
            nack     <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done     <= 1'b0;
            case (hs_r)
                SETW_H_IDLE: begin
                    if (cmd_valid) begin
                        ctl_r  <= {cmd_dev_sel, cmd_addr[9:8]};
                        rd_r   <= cmd_read;
                        len_r  <= cmd_len;
                        nack   <= 1'b0;
                        role_r <= SETW_R_CTLW;
                        tx_r   <= {DEV_CODE, cmd_dev_sel, cmd_addr[9:8], 1'b0}; // RULE_18
                        rx_r   <= cmd_addr[7:0];
                        hs_r   <= SETW_H_START;
                    end
                end
                SETW_H_START: begin
                    if (eob) begin
                        bit_r <= 4'h0;
                        hs_r  <= SETW_H_BYTE;
                    end
                end
                SETW_H_LOAD: begin
                    if (fo_valid) begin
                        tx_r  <= fo_data;
                        bit_r <= 4'h0;
                        hs_r  <= SETW_H_BYTE;
                    end
                end
                SETW_H_STOP: begin
                    if (eob) begin
                        done <= 1'b1;
                        hs_r <= SETW_H_IDLE;
                    end
                end
                SETW_H_BYTE: begin
                    if (eob && bit_r != SETW_ACK_SLOT) begin
                        bit_r <= bit_r + 4'h1;
                        tx_r  <= {tx_r[6:0], 1'b1};
                        if (role_r == SETW_R_RDAT) begin
                            rx_r <= {rx_r[6:0], sda_s_r[1]};
                        end
                    end else if (eob) begin
                        bit_r <= 4'h0;
                        if (role_r != SETW_R_RDAT && !ackd) begin
                            nack <= 1'b1;
                            hs_r <= SETW_H_STOP;
                        end else begin
                            case (role_r)
                                SETW_R_CTLW: begin
                                    role_r <= SETW_R_WADR;
                                    tx_r   <= rx_r;
                                end
                                SETW_R_WADR: begin
                                    role_r <= rd_r ? SETW_R_CTLR : SETW_R_WDAT;
                                    tx_r   <= {DEV_CODE, ctl_r, 1'b1};
                                    hs_r   <= rd_r ? SETW_H_START
                                            : (len_r == 5'h00 ? SETW_H_STOP : SETW_H_LOAD);
                                end
                                SETW_R_WDAT: begin
                                    len_r <= len_r - 5'h01;
                                    hs_r  <= len_r == 5'h01 ? SETW_H_STOP : SETW_H_LOAD;
                                end
                                SETW_R_CTLR: begin
                                    role_r <= SETW_R_RDAT;
                                end
                                default: begin
                                    rd_valid <= 1'b1;
                                    rd_data  <= rx_r;
                                    len_r    <= len_r - 5'h01;
                                    if (len_r == 5'h01) begin
                                        hs_r <= SETW_H_STOP;
                                    end
                                end
                            endcase
                        end
                    end
                end
                default: begin
                    hs_r <= SETW_H_IDLE;
                end
            endcase
        end
    end
endmodule : setw_host
`default_nettype wire

// ---- testbench/setw_checker.sv ----
/*
 link checker on the setw_if wires.
 assumes one ref_clk domain and a synchronous active-high rst.
*/
`timescale 1ns/10ps
`default_nettype none
module setw_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic h_sda_o,
    input wire logic h_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic sda
);
    logic [3:0] rise_r;
    logic       frame_r;
    // scl rises since last start, wrapping per nine-clock byte
    always_ff @(posedge ref_clk) begin
        if (rst || (scl && $fell(sda))) rise_r <= 4'h0;
        else if ($rose(scl)) rise_r <= (rise_r == 4'h8) ? 4'h0 : rise_r + 4'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) frame_r <= 1'b0;
        else if (scl && $fell(sda)) frame_r <= 1'b1;
        else if (scl && $rose(sda)) frame_r <= 1'b0;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_idle_after_rst:
        assert property (disable iff (1'b0) rst |=> (scl && !h_sda_oe && !d_sda_oe))
        else $error("link not idle after reset");
    a_open_drain_only:
        assert property (!d_sda_o && !h_sda_o) else $error("data driven high");
    a_dev_scl_low:
        assert property ($changed(d_sda_oe) |-> !scl) else $error("device data moved in scl high");
    a_nine_clock_frame:
        assert property (scl && $rose(sda) |-> rise_r == 4'h1) else $error("stop not on byte edge");
    a_nack_release:
        assert property ($rose(scl) && rise_r == 4'h8 && sda |-> !d_sda_oe [*8])
        else $error("device drove after missing ack");
    a_ack_held_low:
        assert property ($rose(scl) && d_sda_oe |-> !sda [*4]) else $error("ack not stable");
    a_scl_high_time:
        assert property ($rose(scl) |-> scl [*4]) else $error("scl high phase short");
    a_drive_in_frame:
        assert property (d_sda_oe |-> frame_r) else $error("device drove outside frame");
endmodule : setw_checker
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 bench: host and memory ends joined by one setw_if, plus the checker.
 assumes setw_pkg and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench import setw_pkg::*; ;
    localparam int PROG = 400;
    logic        ref_clk = 1'b0, rst = 1'b1, wp = 1'b0, chip_select_address_pin = 1'b0;
    logic        cmd_valid = 1'b0, cmd_read = 1'b0, cmd_dev_sel = 1'b0, wr_valid = 1'b0;
    logic [9:0]  cmd_addr = 10'h000;
    logic [4:0]  cmd_len = 5'h00;
    logic [7:0]  wr_data = 8'h00, rd_data, rd_buf [0:15];
    logic        wr_ready, rd_valid, done, nack, busy, cmd_ready;
    logic [15:0] busy_cyc = 16'h0000;
    int          failures = 0, tests_run = 0, rd_n = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (rd_valid === 1'b1) begin
        rd_buf[rd_n] = rd_data;
        rd_n = rd_n + 1;
    end
    always @(posedge ref_clk) if (busy === 1'b1) busy_cyc = busy_cyc + 16'h0001;
    setw_if link ();
    setw_host setw_host_i (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_dev_sel(cmd_dev_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_data(rd_data), .done(done), .nack(nack), .link(link));
    setw_dev #(.PROG_CYCLES(PROG)) setw_dev_i (.ref_clk(ref_clk), .rst(rst), .wp(wp),
        .chip_select_address_pin(chip_select_address_pin), .busy(busy), .link(link));
    setw_checker setw_checker_i (.ref_clk(ref_clk), .rst(rst), .scl(link.scl),
        .h_sda_o(link.h_sda_o), .h_sda_oe(link.h_sda_oe), .d_sda_o(link.d_sda_o),
        .d_sda_oe(link.d_sda_oe), .sda(link.sda));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic cmd(input logic rd, input logic sel, input logic [9:0] a, input logic [4:0] n);
        int i;
        rd_n = 0;
        {cmd_valid, cmd_read, cmd_dev_sel, cmd_addr, cmd_len} = {1'b1, rd, sel, a, n};
        @(posedge ref_clk);
        #2 cmd_valid = 1'b0;
        check(cmd_ready, 1'b0);
        for (i = 0; done !== 1'b1; i++) begin
            @(posedge ref_clk);
            #2;
            if (i > 20000) begin
                failures++;
                complete_run();
            end
        end
    endtask : cmd
    task automatic page_wrap();
        int i;
        wr_valid = 1'b1;
        for (i = 0; i < SETW_FIFO_DEPTH; i++) begin
            wr_data = 8'ha0 + 8'(i);
            @(posedge ref_clk);
            #2;
        end
        wr_valid = 1'b0;
        check(wr_ready, 1'b0);
        busy_cyc = 16'h0000;
        cmd(1'b0, 1'b0, 10'h2fc, 5'h08);
        check(nack, 1'b0);
        check(wr_ready, 1'b1);
        cmd(1'b0, 1'b0, 10'h2fc, 5'h00);
        check(nack, 1'b1);
        for (i = 0; i < PROG && busy !== 1'b0; i++) begin
            @(posedge ref_clk);
            #2;
        end
        if (busy !== 1'b0) begin
            failures++;
            complete_run();
        end
        check(busy_cyc, 16'(PROG));
        // pointer wraps inside the page, so 2f0.. holds the last four bytes
        cmd(1'b1, 1'b0, 10'h2f0, 5'h04);
        check(16'(rd_n), 16'h0004);
        for (i = 0; i < 4; i++) check(rd_buf[i], 8'ha4 + 8'(i));
        cmd(1'b1, 1'b0, 10'h2fc, 5'h04);
        for (i = 0; i < 4; i++) check(rd_buf[i], 8'ha0 + 8'(i));
    endtask : page_wrap
    task automatic protect();
        wp = 1'b1;
        wr_valid = 1'b1;
        wr_data = 8'h5a;
        @(posedge ref_clk);
        #2 wr_valid = 1'b0;
        busy_cyc = 16'h0000;
        cmd(1'b0, 1'b0, 10'h2f0, 5'h01);
        check(nack, 1'b1);
        check(busy_cyc, 16'h0000);
        cmd(1'b1, 1'b0, 10'h2f0, 5'h01);
        check(rd_buf[0], 8'ha4);
        wp = 1'b0;
    endtask : protect
    task automatic chip_sel();
        int s;
        chip_select_address_pin = 1'b1;
        // block bits differ between tries and must not matter
        for (s = 0; s < 2; s++) begin
            cmd(1'b0, s[0], {s[0], s[0], 8'h00}, 5'h00);
            check(nack, !s[0]);
        end
    endtask : chip_sel
    initial begin
        repeat (12) @(posedge ref_clk);
        #2 rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #2;
        page_wrap();
        protect();
        chip_sel();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
